/* include/phy_mgmt_defines.vh */
// Purpose: constants for the management serial block
// Assumes: included by src/phy_mgmt_control_status.v
// Notes:   register numbers, bit positions, reset values, frame codes
`ifndef PHY_MGMT_DEFINES_VH
`define PHY_MGMT_DEFINES_VH
`define REG_CONTROL      5'h00
`define REG_STATUS       5'h01
`define REG_ID_HIGH      5'h02
`define REG_ID_LOW       5'h03
`define CTL_RESET        15
`define CTL_LOOPBACK     14
`define CTL_SPEED        13
`define CTL_ANEG_EN      12
`define CTL_POWER_DOWN   11
`define CTL_ISOLATE      10
`define CTL_ANEG_RESTART 9
`define CTL_DUPLEX       8
`define CTL_COL_TEST     7
`define CTL_RESET_VALUE  16'h3000
`define ST_T4            15
`define ST_TX_FD         14
`define ST_TX_HD         13
`define ST_FD10          12
`define ST_HD10          11
`define ST_ANEG_DONE     5
`define ST_REMOTE_FAULT  4
`define ST_ANEG_ABLE     3
`define ST_LINK          2
`define ST_JABBER        1
`define ST_EXTENDED      0
`define PREAMBLE_MIN     6'h20
`define OP_READ          2'h2
`define OP_WRITE         2'h1
`define START_CODE       2'h1
`define CNT_HEADER       6'h0d
`define CNT_TURN         6'h0f
`define CNT_LAST         6'h1f
`endif

/* src/phy_mgmt_control_status.v */
// Purpose: management serial slave with control and status registers
// Assumes: mgmt clock is a pin, sampled by clock_in; straps are static
// Notes:   data bits sampled on rising and driven on falling management clock edges
//
// How it works
// - act only on accesses to own address
// - latch address straps when reset releases
// - matching read shifts sixteen bits out
// - matching write to register 0 stores control bits 14 to 7
// - register 0 control, register 1 status
// - loopback bit routes transmit into receive
// - speed bit picks 100 or 10
// - enable bit turns on auto-negotiation
// - power down bit stops core
// - isolate bit isolates bus, strap default
// - restart bit restarts negotiation, self-clears
// - duplex bit selects full duplex
// - collision test echoes transmit enable
// - 100BASE-TX ability bits read zero
// - ability bits read-only from configuration
// - negotiation complete flag reported
// - remote fault flag reported
// - link pass state reported
// - jabber latches high
// - extended capability bit reads one
// - registers 2, 3 give identifier codes
// - ability defaults follow strap pins
`timescale 1ns/1ns
`include "phy_mgmt_defines.vh"
module phy_mgmt_control_status
#(
   parameter [15:0] ID_HIGH_VALUE = 16'h1234,   // arbitrary value
   parameter [15:0] ID_LOW_VALUE  = 16'h5678    // arbitrary value
)
(
   input  wire        clock_in,
   input  wire        rst_in,
   input  wire        mdc_in,
   input  wire        mdio_in,
   output reg         mdio_out,
   output reg         mdio_oe_out,
   input  wire [4:0]  phy_address_strap_in,
   input  wire        isolate_default_strap_in,
   input  wire        t4_ability_strap_in,
   input  wire        full_duplex_ability_strap_in,
   input  wire        half_duplex_ability_strap_in,
   input  wire        default_strap_a_in,
   input  wire        aneg_complete_in,
   input  wire        remote_fault_in,
   input  wire        link_pass_in,
   input  wire        jabber_in,
   input  wire        tx_en_in,
   output reg         loopback_out,
   output reg         speed_100_out,
   output reg         aneg_enable_out,
   output reg         power_down_out,
   output reg         isolate_out,
   output reg         aneg_restart_out,
   output reg         full_duplex_out,
   output reg         col_test_out
);
   localparam ST_IDLE = 3'h0;
   localparam ST_HEAD = 3'h1;
   localparam ST_TURN = 3'h2;
   localparam ST_DATA = 3'h3;
   localparam ST_SKIP = 3'h4;

   reg  [1:0]  mdc_sync_reg;
   reg  [1:0]  mdio_sync_reg;
   reg  [2:0]  strap_sync0_reg;
   reg  [2:0]  strap_sync_reg;
   reg  [6:0]  cfg_sync0_reg;
   reg  [6:0]  cfg_sync_reg;
   reg  [4:0]  addr_sync0_reg;
   reg  [4:0]  addr_sync_reg;
   reg         mdc_prev_reg;
   reg         released_reg;
   reg         load_reg;
   reg  [4:0]  phy_address_reg;
   reg  [3:0]  ability_reg;
   reg         iso_default_reg;
   reg  [2:0]  state_reg;
   reg  [5:0]  count_reg;
   reg  [5:0]  ones_reg;
   reg  [15:0] shift_reg;
   reg         is_read_reg;
   reg  [4:0]  regnum_reg;
   reg  [15:0] control_reg;
   reg         jabber_reg;
   reg         reset_pulse_reg;
   wire        mdc_rise;
   wire        mdc_fall;
   wire        bit_in;
   wire [15:0] status_word;
   wire [15:0] control_default;
   wire [15:0] read_word;

   function [15:0] select_word;
      input [4:0]  num;
      input [15:0] ctl;
      input [15:0] st;
      begin
         case (num)
            `REG_CONTROL: select_word = ctl;
            `REG_STATUS:  select_word = st;
            `REG_ID_HIGH: select_word = ID_HIGH_VALUE;
            `REG_ID_LOW:  select_word = ID_LOW_VALUE;
            default:      select_word = 16'h0000;
         endcase
      end
   endfunction

   assign mdc_rise = mdc_sync_reg[1] & ~mdc_prev_reg;
   assign mdc_fall = ~mdc_sync_reg[1] & mdc_prev_reg;
   assign bit_in   = mdio_sync_reg[1];
   assign control_default = (`CTL_RESET_VALUE | ({15'h0000, iso_default_reg} << `CTL_ISOLATE))
                            & ~({15'h0000, ~ability_reg[0]} << `CTL_ANEG_EN);

   // status word assembly
   assign status_word = {ability_reg[3], 1'b0, 1'b0,
                         ability_reg[2], ability_reg[1], 5'h00,
                         cfg_sync_reg[0], cfg_sync_reg[1],
                         ability_reg[0], cfg_sync_reg[2],
                         jabber_reg, 1'b1};
   assign read_word = select_word(regnum_reg, control_reg, status_word);

   // management pin synchronisers
   always @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         mdc_sync_reg    <= 2'h0;
         mdio_sync_reg   <= 2'h3;
         mdc_prev_reg    <= 1'b0;
      end
      else
      begin
         mdc_sync_reg    <= {mdc_sync_reg[0], mdc_in};
         mdio_sync_reg   <= {mdio_sync_reg[0], mdio_in};
         mdc_prev_reg    <= mdc_sync_reg[1];
      end
   end

   // strap and status synchronisers, running through reset
   always @(posedge clock_in)
   begin
      strap_sync0_reg <= {t4_ability_strap_in, full_duplex_ability_strap_in,
                          half_duplex_ability_strap_in};
      strap_sync_reg  <= strap_sync0_reg;
      cfg_sync0_reg   <= {tx_en_in, jabber_in, isolate_default_strap_in,
                          default_strap_a_in, link_pass_in, remote_fault_in,
                          aneg_complete_in};
      cfg_sync_reg    <= cfg_sync0_reg;
      addr_sync0_reg  <= phy_address_strap_in;
      addr_sync_reg   <= addr_sync0_reg;
   end

   // strap capture at reset release, defaults loaded one clock later
   always @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         released_reg    <= 1'b0;
         load_reg        <= 1'b0;
         phy_address_reg <= 5'h00;
         ability_reg     <= 4'h0;
         iso_default_reg <= 1'b0;
      end
      else
      begin
         load_reg <= !released_reg;
         if (!released_reg)
         begin
            released_reg    <= 1'b1;
            phy_address_reg <= addr_sync_reg;
            ability_reg     <= {strap_sync_reg, ~cfg_sync_reg[3]};
            iso_default_reg <= cfg_sync_reg[4];
         end
      end
   end

   // frame engine and registers
   always @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         state_reg       <= ST_IDLE;
         count_reg       <= 6'h00;
         ones_reg        <= 6'h00;
         shift_reg       <= 16'h0000;
         is_read_reg     <= 1'b0;
         regnum_reg      <= 5'h00;
         control_reg     <= `CTL_RESET_VALUE;
         jabber_reg      <= 1'b0;
         reset_pulse_reg <= 1'b0;
         mdio_out        <= 1'b0;
         mdio_oe_out     <= 1'b0;
      end
      else
      begin
         reset_pulse_reg <= 1'b0;
         if (cfg_sync_reg[5])
            jabber_reg <= 1'b1;
         if (load_reg || reset_pulse_reg)
         begin
            control_reg <= control_default;
            if (reset_pulse_reg)
               jabber_reg <= cfg_sync_reg[5];
         end
         else if (control_reg[`CTL_ANEG_RESTART])
            control_reg[`CTL_ANEG_RESTART] <= 1'b0;
         if (mdc_fall && state_reg == ST_DATA && is_read_reg)
         begin
            mdio_out <= shift_reg[15];
            shift_reg <= {shift_reg[14:0], 1'b0};
         end
         if (mdc_fall && state_reg == ST_TURN && is_read_reg && count_reg == `CNT_TURN)
         begin
            mdio_oe_out <= 1'b1;
            mdio_out    <= 1'b0;
         end
         if (mdc_rise)
         begin
            case (state_reg)
               ST_IDLE:
               begin
                  mdio_oe_out <= 1'b0;
                  if (bit_in)
                     ones_reg <= (ones_reg == `PREAMBLE_MIN) ? ones_reg : ones_reg + 6'h01;
                  else
                  begin
                     ones_reg <= 6'h00;
                     if (ones_reg == `PREAMBLE_MIN)
                     begin
                        state_reg <= ST_HEAD;
                        count_reg <= 6'h01;
                        shift_reg <= 16'h0000;
                     end
                  end
               end
               ST_HEAD:
               begin
                  shift_reg <= {shift_reg[14:0], bit_in};
                  count_reg <= count_reg + 6'h01;
                  if (count_reg == `CNT_HEADER)
                  begin
                     regnum_reg  <= {shift_reg[3:0], bit_in};
                     is_read_reg <= (shift_reg[10:9] == `OP_READ);
                     if (shift_reg[12:11] == `START_CODE
                         && (shift_reg[10:9] == `OP_READ || shift_reg[10:9] == `OP_WRITE)
                         && shift_reg[8:4] == phy_address_reg)
                        state_reg <= ST_TURN;
                     else
                        state_reg <= ST_SKIP;
                  end
               end
               ST_TURN:
               begin
                  count_reg <= count_reg + 6'h01;
                  if (count_reg == `CNT_TURN)
                  begin
                     state_reg <= ST_DATA;
                     if (is_read_reg)
                     begin
                        shift_reg <= read_word;
                        if (regnum_reg == `REG_STATUS && !cfg_sync_reg[5])
                           jabber_reg <= 1'b0;
                     end
                  end
               end
               ST_DATA:
               begin
                  count_reg <= count_reg + 6'h01;
                  if (!is_read_reg)
                     shift_reg <= {shift_reg[14:0], bit_in};
                  if (count_reg == `CNT_LAST)
                  begin
                     state_reg <= ST_IDLE;
                     if (!is_read_reg && regnum_reg == `REG_CONTROL)
                     begin
                        control_reg <= {1'b0, shift_reg[13:6], 7'h00};
                        reset_pulse_reg <= shift_reg[14];
                     end
                  end
               end
               ST_SKIP:
               begin
                  mdio_oe_out <= 1'b0;
                  count_reg <= count_reg + 6'h01;
                  if (count_reg == `CNT_LAST)
                     state_reg <= ST_IDLE;
               end
               default: state_reg <= ST_IDLE;
            endcase
         end
      end
   end

   // control outputs
   always @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         loopback_out     <= 1'b0;
         speed_100_out    <= 1'b1;
         aneg_enable_out  <= 1'b1;
         power_down_out   <= 1'b0;
         isolate_out      <= 1'b0;
         aneg_restart_out <= 1'b0;
         full_duplex_out  <= 1'b0;
         col_test_out     <= 1'b0;
      end
      else
      begin
         loopback_out     <= control_reg[`CTL_LOOPBACK];
         speed_100_out    <= control_reg[`CTL_SPEED];
         aneg_enable_out  <= control_reg[`CTL_ANEG_EN];
         power_down_out   <= control_reg[`CTL_POWER_DOWN];
         isolate_out      <= control_reg[`CTL_ISOLATE];
         aneg_restart_out <= control_reg[`CTL_ANEG_RESTART];
         full_duplex_out  <= control_reg[`CTL_DUPLEX];
         col_test_out     <= control_reg[`CTL_COL_TEST] & cfg_sync_reg[6];
      end
   end
endmodule // phy_mgmt_control_status

/* test/phy_mgmt_monitor.sv */
// Purpose: port checks for the management serial block
// Assumes: clock_in samples every port
// Notes:   bound into every instance of the block
`timescale 1ns/1ns
module phy_mgmt_monitor
(
   input wire clock_in,
   input wire rst_in,
   input wire mdc_in,
   input wire tx_en_in,
   input wire mdio_oe_out,
   input wire loopback_out,
   input wire speed_100_out,
   input wire aneg_enable_out,
   input wire power_down_out,
   input wire isolate_out,
   input wire aneg_restart_out,
   input wire full_duplex_out,
   input wire col_test_out
);
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (rst_in);
   chk_restart_pulse:
   assert property ($rose(aneg_restart_out) |=> !aneg_restart_out)
      else $error("restart pulse too long");
   chk_restart_idle:
   assert property (mdc_in [*8] |-> !aneg_restart_out)
      else $error("restart high while idle");
   chk_oe_release:
   assert property (mdc_in [*8] |-> !mdio_oe_out)
      else $error("data line held while idle");
   chk_oe_span:
   assert property ($rose(mdio_oe_out) |-> ##[1:200] !mdio_oe_out)
      else $error("data line held too long");
   chk_ctl_hold:
   assert property (mdc_in [*8] |->
      $stable({loopback_out, power_down_out, isolate_out, full_duplex_out}))
      else $error("control output moved while idle");
   chk_speed_hold:
   assert property (mdc_in [*8] |-> $stable({speed_100_out, aneg_enable_out}))
      else $error("speed output moved while idle");
   chk_col_off:
   assert property (!tx_en_in [*4] |-> !col_test_out)
      else $error("collision without transmit");
   chk_col_cause:
   assert property (col_test_out |-> $past(tx_en_in, 3))
      else $error("collision without cause");
   cover property ($rose(mdio_oe_out));
   cover property ($rose(aneg_restart_out));
   cover property ($rose(col_test_out));
   cover property ($fell(loopback_out));
endmodule // phy_mgmt_monitor
bind phy_mgmt_control_status phy_mgmt_monitor u_mon (.*);

/* test/sta_model.sv */
// Purpose: station model clocking management frames
// Assumes: data line has a pull-up when nobody drives
// Notes:   drives after falling clock, samples before next fall
`timescale 1ns/1ns
module sta_model
(
   input  wire        clock_in,
   input  wire        mdio_in,
   output reg         mdc_out,
   output reg         sd_out,
   output reg         soe_out,
   output reg  [15:0] rd_word_out,
   output reg         rd_valid_out
);
   reg [63:0] f;
   integer    p;
   initial
   begin
      mdc_out = 1'b0;
      sd_out = 1'b1;
      soe_out = 1'b0;
      rd_word_out = 16'h0000;
      rd_valid_out = 1'b0;
   end
   task frame(input [1:0] op, input [4:0] ad, input [4:0] rg, input [15:0] wd);
      begin
         f = {32'hffffffff, 2'h1, op, ad, rg, 2'h2, wd};
         for (p = 0; p < 65; p = p + 1)
         begin
            @(posedge clock_in);
            if (p > 48)
               rd_word_out <= {rd_word_out[14:0], mdio_in};
            mdc_out <= 1'b0;
            sd_out <= (p < 64) ? f[63 - p] : 1'b1;
            soe_out <= (p < 46) || (op == 2'h1 && p < 64);
            repeat (4) @(posedge clock_in);
            mdc_out <= 1'b1;
            repeat (3) @(posedge clock_in);
         end
         rd_valid_out <= (op == 2'h2);
         @(posedge clock_in);
         rd_valid_out <= 1'b0;
         repeat (12) @(posedge clock_in);
      end
   endtask
endmodule // sta_model

/* test/tb.sv */
// Purpose: self-checking bench for the management serial block
// Assumes: station model drives the management pins
// Notes:   read results checked against a queue of notes
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) \
   begin n_fail++; $display("mismatch %0t %h %h", $time, a, b); end end
module tb;
   localparam [15:0] IDH = 16'h2a5c;   // arbitrary value
   localparam [15:0] IDL = 16'h9e31;   // arbitrary value
   reg         clock_in, rst_in, iso, t4, fd, hd, sa, anc, rf, lk, jb, txe, saw;
   reg  [4:0]  adr;
   reg  [15:0] d;
   reg  [31:0] e, rn;
   reg  [31:0] exq[$];
   integer     seed, i, n_fail, checks_done;
   wire        mdc, so, soe, rv, mo, moe, lb, sp, ae, pd, isl, rs, fdx, col;
   wire [15:0] rw;
   wire [15:0] dflt = {2'h0, 1'b1, ~sa, 1'b0, iso, 10'h000};
   wire [15:0] st = {t4, 2'h0, fd, hd, 5'h00, anc, rf, ~sa, lk, jb, 1'b1};
   wire        mw = moe ? mo : (soe ? so : 1'b1);
   phy_mgmt_control_status #(.ID_HIGH_VALUE(IDH), .ID_LOW_VALUE(IDL)) dut
   (
      .clock_in(clock_in), .rst_in(rst_in), .mdc_in(mdc), .mdio_in(mw),
      .mdio_out(mo), .mdio_oe_out(moe), .phy_address_strap_in(adr),
      .isolate_default_strap_in(iso), .t4_ability_strap_in(t4),
      .full_duplex_ability_strap_in(fd), .half_duplex_ability_strap_in(hd),
      .default_strap_a_in(sa), .aneg_complete_in(anc), .remote_fault_in(rf),
      .link_pass_in(lk), .jabber_in(jb), .tx_en_in(txe), .loopback_out(lb),
      .speed_100_out(sp), .aneg_enable_out(ae), .power_down_out(pd),
      .isolate_out(isl), .aneg_restart_out(rs), .full_duplex_out(fdx),
      .col_test_out(col)
   );
   sta_model sta
   (
      .clock_in(clock_in), .mdio_in(mw), .mdc_out(mdc), .sd_out(so),
      .soe_out(soe), .rd_word_out(rw), .rd_valid_out(rv)
   );
   task print_verdict;
      begin
         $display("checks %0d mismatches %0d", checks_done, n_fail);
         if (n_fail == 0 && checks_done > 0)
            $display("*** PASS ***");
         else
            $display("*** FAIL ***");
         $finish;
      end
   endtask
   task rd(input [4:0] a, input [4:0] r, input [31:0] x);
      begin
         exq.push_back(x);
         sta.frame(2'h2, a, r, 16'h0000);
      end
   endtask
   initial
   begin
      clock_in = 1'b0;
      forever #10 clock_in = ~clock_in;
   end
   always @(posedge clock_in)
      if (rv === 1'b1)
      begin
         e = exq.pop_front();
         `CHK(rw & e[31:16], e[15:0])
      end
   always @(posedge clock_in)
      if (rs === 1'b1)
         saw <= 1'b1;
   initial
   begin
      #600000;
      n_fail = n_fail + 1;
      print_verdict;
   end
   initial
   begin
      seed = 58853;
      n_fail = 0;
      checks_done = 0;
      saw = 1'b0;
      rn = $random(seed);
      {adr, t4, fd, hd} = rn[7:0];
      {iso, sa, anc, rf, lk, jb, txe} = {rn[12:11], 5'h00};
      rst_in = 1'b1;
      repeat (12) @(posedge clock_in);
      rst_in <= 1'b0;
      repeat (8) @(posedge clock_in);
      {anc, rf, lk} <= rn[10:8];
      rd(adr, 5'h00, {16'hffff, dflt});
      rd(adr, 5'h01, {16'hffff, st});
      sta.frame(2'h1, adr, 5'h01, 16'h0000);
      rd(adr, 5'h01, {16'hffff, st});
      $display("test 1 done");
      rd(adr, 5'h02, {16'hffff, IDH});
      rd(adr, 5'h03, {16'hffff, IDL});
      rd(adr, 5'h09, 32'hffff0000);
      $display("test 2 done");
      rn = $random(seed);
      txe <= 1'b1;
      for (i = 0; i < 2; i = i + 1)
      begin
         d = (i ? ~rn[15:0] : rn[15:0]) & 16'h7d80;
         sta.frame(2'h1, adr, 5'h00, d);
         rd(adr, 5'h00, {16'hffff, d});
         `CHK({lb,sp,ae,pd,isl,fdx,col}, {d[14:10],d[8:7]})
      end
      d = 16'h3080;
      sta.frame(2'h1, adr, 5'h00, d);
      txe <= 1'b0;
      repeat (6) @(posedge clock_in);
      `CHK(col, 1'b0)
      txe <= 1'b1;
      repeat (6) @(posedge clock_in);
      `CHK(col, 1'b1)
      $display("test 3 done");
      sta.frame(2'h1, adr ^ 5'h01, 5'h00, 16'h0000);
      rd(adr ^ 5'h01, 5'h00, 32'hffffffff);
      rd(adr, 5'h00, {16'hffff, d});
      $display("test 4 done");
      jb <= 1'b1;
      rd(adr, 5'h01, {16'hffff, st | 16'h0002});
      jb <= 1'b0;
      rd(adr, 5'h01, {16'hffff, st | 16'h0002});
      rd(adr, 5'h01, {16'hffff, st});
      $display("test 5 done");
      sta.frame(2'h1, adr, 5'h00, dflt | 16'h0200);
      `CHK(saw, 1'b1)
      rd(adr, 5'h00, {16'hffff, dflt});
      sta.frame(2'h1, adr, 5'h00, 16'hc100);
      rd(adr, 5'h00, {16'hffff, dflt});
      `CHK({lb, fdx}, 2'b00)
      $display("test 6 done");
      print_verdict;
   end
endmodule // tb
